// *** src/gpz_regs.svh ***
// Register offsets, field positions and reset values of the GPIO ports.
// Assumes an includer that compiles it once per unit; guarded anyway.
`ifndef GPZ_REGS_SVH
`define GPZ_REGS_SVH

// Bus widths
`define GPZ_ADDR_W 16
`define GPZ_DATA_W 8

// Register offsets
`define GPZ_P0_LATCH_OFS 16'h0000
`define GPZ_P1_LATCH_OFS 16'h0001
`define GPZ_P2_LATCH_OFS 16'h0002
`define GPZ_P0_DIR_OFS 16'h000A
`define GPZ_P1_DIR_OFS 16'h000B
`define GPZ_P0_DRIVE_OFS 16'h1F80
`define GPZ_IRQ_STAT_OFS 16'h1F90
`define GPZ_IRQ_MASK_OFS 16'h1F91
`define GPZ_SYS_CTRL_OFS 16'h1F92

// Field positions
`define GPZ_KEEP_BIT 0
`define GPZ_STOP_PIN 0

// Reset values
`define GPZ_P0_LATCH_RST 8'h00
`define GPZ_P0_DIR_RST 8'h00
`define GPZ_P0_DRIVE_RST 8'h00
`define GPZ_P1_LATCH_RST 8'h00
`define GPZ_P1_DIR_RST 8'h00
`define GPZ_P2_LATCH_RST 8'hFF
`define GPZ_IRQ_STAT_RST 8'h00
`define GPZ_IRQ_MASK_RST 8'h00
`define GPZ_SYS_CTRL_RST 8'h00
`define GPZ_UNMAPPED_VAL 8'h00

`endif

// *** src/gpz_pkg.sv ***
// Types shared by the GPIO port block.
// Assumes gpz_regs.svh is on the include path.
`include "gpz_regs.svh"

package gpz_pkg;

	typedef logic [`GPZ_DATA_W-1:0] gpz_byte_t;
	typedef logic [`GPZ_ADDR_W-1:0] gpz_addr_t;

	// One register bus request, all fields valid in the strobe cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic rmw;
		gpz_addr_t addr;
		gpz_byte_t wdata;
	} gpz_bus_req_t;

endpackage

// *** src/gpz_pin_cell.sv ***
// Pad drive logic for one port of W pins.
// Assumes registered latch, direction and drive-type inputs.
`timescale 1ns/10ps
`default_nettype none

module gpz_pin_cell #(
	parameter int W = 8
) (
	// Port state
	input wire logic [W-1:0] latch,
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] open_drain,
	input wire logic [W-1:0] force_off,
	// Pad side
	output logic [W-1:0] pad_o,
	output logic [W-1:0] pad_oe
);

	// Refused while the design is built, not at run time
	if (W < 1 || W > 8) begin : g_bad_width
		$error("gpz_pin_cell: W must be 1 to 8");
	end

	// Open-drain pins only ever pull low
	always_comb begin
		pad_o = latch & ~open_drain;
		pad_oe = dir & ~force_off & (~open_drain | ~latch);
	end

endmodule

`default_nettype wire

// *** src/gpz_ports.sv ***
// Three general-purpose I/O ports behind a simple register port.
// Assumes one clock, synchronous pin inputs and a single bus master.
// Contract
// - First port: four two-way pins
// - First port direction per pin, resets input
// - First port latch holds writes, resets zero
// - First port drive type: 0 push-pull, 1 open-drain
// - Open-drain RMW reads latch, else pin level
// - Second port: eight pins, direction resets input
// - Second port latch resets to zero
// - Third port: three pins, latch resets ones
// - Falling edge on pin zero sets interrupt
// - Pin zero floats in stop regardless
// - Third port upper read bits indeterminate
// - Third port RMW reads latch, else pins
// - Outputs latched, inputs read straight from pins
`timescale 1ns/10ps
`default_nettype none

`include "gpz_regs.svh"

module gpz_ports
	import gpz_pkg::*;
#(
	parameter int P0_W = 4,
	parameter int P1_W = 8,
	parameter int P2_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire gpz_bus_req_t bus,
	output gpz_byte_t rdata,
	// Chip power state
	input wire logic stop_active,
	// First port pins
	input wire logic [P0_W-1:0] p0_in,
	output logic [P0_W-1:0] p0_out,
	output logic [P0_W-1:0] p0_oe,
	// Second port pins
	input wire logic [P1_W-1:0] p1_in,
	output logic [P1_W-1:0] p1_out,
	output logic [P1_W-1:0] p1_oe,
	// Third port pins
	input wire logic [P2_W-1:0] p2_in,
	output logic [P2_W-1:0] p2_out,
	output logic [P2_W-1:0] p2_oe,
	// Interrupt
	output logic irq
);

	// Read data are one byte, so wider ports cannot be served
	if (P0_W < 1 || P0_W > `GPZ_DATA_W) begin : g_bad_p0_w
		$error("gpz_ports: P0_W out of range");
	end
	if (P1_W < 1 || P1_W > `GPZ_DATA_W) begin : g_bad_p1_w
		$error("gpz_ports: P1_W out of range");
	end
	if (P2_W < 1 || P2_W > `GPZ_DATA_W) begin : g_bad_p2_w
		$error("gpz_ports: P2_W out of range");
	end

	// Per-bit choice between latch and pin for a read
	function automatic gpz_byte_t read_mix(
		input gpz_byte_t latch_v,
		input gpz_byte_t pin_v,
		input gpz_byte_t sel_latch
	);
		read_mix = (latch_v & sel_latch) | (pin_v & ~sel_latch);
	endfunction

	// Decode of one register hit
	function automatic logic hit(
		input gpz_addr_t addr,
		input gpz_addr_t ofs
	);
		hit = (addr == ofs);
	endfunction

	// First port state
	logic [P0_W-1:0] first_port_latch;
	logic [P0_W-1:0] first_port_direction;
	logic [P0_W-1:0] first_port_drive_type;
	logic [P0_W-1:0] next_first_port_latch;
	logic [P0_W-1:0] next_first_port_direction;
	logic [P0_W-1:0] next_first_port_drive_type;

	// Second port state
	logic [P1_W-1:0] second_port_latch;
	logic [P1_W-1:0] second_port_direction;
	logic [P1_W-1:0] next_second_port_latch;
	logic [P1_W-1:0] next_second_port_direction;

	// Third port state
	logic [P2_W-1:0] third_port_latch;
	logic [P2_W-1:0] next_third_port_latch;

	// System control and interrupts
	logic stop_output_keep;
	logic next_stop_output_keep;
	logic [P2_W-1:0] irq_status;
	logic [P2_W-1:0] irq_mask;
	logic [P2_W-1:0] next_irq_status;
	logic [P2_W-1:0] next_irq_mask;
	logic [P2_W-1:0] p2_prev;
	logic [P2_W-1:0] next_p2_prev;
	logic [P2_W-1:0] p2_fall;

	// Read data
	gpz_byte_t next_rdata;

	// Output gating
	logic stop_float;
	logic [P0_W-1:0] p0_off;
	logic [P1_W-1:0] p1_off;
	logic [P2_W-1:0] p2_off;
	gpz_byte_t p0_sel;
	gpz_byte_t p2_sel;

	// First port registers
	always_comb begin
		next_first_port_latch = first_port_latch;
		next_first_port_direction = first_port_direction;
		next_first_port_drive_type = first_port_drive_type;
		if (bus.wr) begin
			// Upper data bits beyond the port width are dropped
			if (hit(bus.addr, `GPZ_P0_LATCH_OFS)) begin
				next_first_port_latch = bus.wdata[P0_W-1:0];
			end
			if (hit(bus.addr, `GPZ_P0_DIR_OFS)) begin
				next_first_port_direction = bus.wdata[P0_W-1:0];
			end
			if (hit(bus.addr, `GPZ_P0_DRIVE_OFS)) begin
				next_first_port_drive_type = bus.wdata[P0_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			first_port_latch <= P0_W'(`GPZ_P0_LATCH_RST);
			first_port_direction <= P0_W'(`GPZ_P0_DIR_RST);
			first_port_drive_type <= P0_W'(`GPZ_P0_DRIVE_RST);
		end else begin
			first_port_latch <= next_first_port_latch;
			first_port_direction <= next_first_port_direction;
			first_port_drive_type <= next_first_port_drive_type;
		end
	end

	// Second port registers
	always_comb begin
		next_second_port_latch = second_port_latch;
		next_second_port_direction = second_port_direction;
		if (bus.wr) begin
			if (hit(bus.addr, `GPZ_P1_LATCH_OFS)) begin
				next_second_port_latch = bus.wdata[P1_W-1:0];
			end
			if (hit(bus.addr, `GPZ_P1_DIR_OFS)) begin
				next_second_port_direction = bus.wdata[P1_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			second_port_latch <= P1_W'(`GPZ_P1_LATCH_RST);
			second_port_direction <= P1_W'(`GPZ_P1_DIR_RST);
		end else begin
			second_port_latch <= next_second_port_latch;
			second_port_direction <= next_second_port_direction;
		end
	end

	// Third port latch and system control
	always_comb begin
		next_third_port_latch = third_port_latch;
		next_stop_output_keep = stop_output_keep;
		next_irq_mask = irq_mask;
		if (bus.wr) begin
			if (hit(bus.addr, `GPZ_P2_LATCH_OFS)) begin
				next_third_port_latch = bus.wdata[P2_W-1:0];
			end
			if (hit(bus.addr, `GPZ_SYS_CTRL_OFS)) begin
				next_stop_output_keep = bus.wdata[`GPZ_KEEP_BIT];
			end
			if (hit(bus.addr, `GPZ_IRQ_MASK_OFS)) begin
				next_irq_mask = bus.wdata[P2_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			third_port_latch <= P2_W'(`GPZ_P2_LATCH_RST);
			stop_output_keep <= 1'(`GPZ_SYS_CTRL_RST);
			irq_mask <= P2_W'(`GPZ_IRQ_MASK_RST);
		end else begin
			third_port_latch <= next_third_port_latch;
			stop_output_keep <= next_stop_output_keep;
			irq_mask <= next_irq_mask;
		end
	end

	// Third port edge detection
	// The pad level is watched, so the device's own output edge counts too
	// Raw pin sampled; a one-cycle glitch still sets a flag
	always_comb begin
		next_p2_prev = p2_in;
		p2_fall = p2_prev & ~p2_in;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// Released latch means pull-up idle, so start high
			p2_prev <= P2_W'(`GPZ_P2_LATCH_RST);
		end else begin
			p2_prev <= next_p2_prev;
		end
	end

	// Sticky status, cleared by a read; a new edge beats the clear
	always_comb begin
		next_irq_status = irq_status;
		if (bus.rd && hit(bus.addr, `GPZ_IRQ_STAT_OFS)) begin
			next_irq_status = '0;
		end
		next_irq_status = next_irq_status | p2_fall;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_status <= P2_W'(`GPZ_IRQ_STAT_RST);
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Level output; software drops it by reading the status
	assign irq = |(irq_status & irq_mask);

	// Read path
	// Third port gives its whole latch back in a modify cycle
	always_comb begin
		// Only open-drain bits of the first port read back the latch
		p0_sel = bus.rmw ? `GPZ_DATA_W'(first_port_drive_type) : '0;
		p2_sel = bus.rmw ? `GPZ_DATA_W'({P2_W{1'b1}}) : '0;
	end

	always_comb begin
		next_rdata = `GPZ_UNMAPPED_VAL;
		if (bus.rd) begin
			if (hit(bus.addr, `GPZ_P0_LATCH_OFS)) begin
				// Unused upper bits read zero
				next_rdata = read_mix(`GPZ_DATA_W'(first_port_latch),
					`GPZ_DATA_W'(p0_in), p0_sel);
			end else if (hit(bus.addr, `GPZ_P1_LATCH_OFS)) begin
				// Pins sampled raw; software must debounce
				next_rdata = `GPZ_DATA_W'(p1_in);
			end else if (hit(bus.addr, `GPZ_P2_LATCH_OFS)) begin
				// Undefined upper bits are given as zero
				next_rdata = read_mix(`GPZ_DATA_W'(third_port_latch),
					`GPZ_DATA_W'(p2_in), p2_sel);
			end else if (hit(bus.addr, `GPZ_P0_DIR_OFS)) begin
				next_rdata = `GPZ_DATA_W'(first_port_direction);
			end else if (hit(bus.addr, `GPZ_P1_DIR_OFS)) begin
				next_rdata = `GPZ_DATA_W'(second_port_direction);
			end else if (hit(bus.addr, `GPZ_P0_DRIVE_OFS)) begin
				next_rdata = `GPZ_DATA_W'(first_port_drive_type);
			end else if (hit(bus.addr, `GPZ_IRQ_STAT_OFS)) begin
				next_rdata = `GPZ_DATA_W'(irq_status);
			end else if (hit(bus.addr, `GPZ_IRQ_MASK_OFS)) begin
				next_rdata = `GPZ_DATA_W'(irq_mask);
			end else if (hit(bus.addr, `GPZ_SYS_CTRL_OFS)) begin
				next_rdata = `GPZ_DATA_W'(stop_output_keep);
			end else begin
				next_rdata = `GPZ_UNMAPPED_VAL;
			end
		end
	end

	// Between reads the bus sees zero, never stale data
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= `GPZ_UNMAPPED_VAL;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Stop mode output gating
	// Holding drive in stop trades current for defined pin levels
	always_comb begin
		stop_float = stop_active & ~stop_output_keep;
		p0_off = {P0_W{stop_float}};
		p1_off = {P1_W{stop_float}};
		p2_off = {P2_W{stop_float}};
		// Pin zero is the stop pin, so it floats whatever the keep bit
		p2_off[`GPZ_STOP_PIN] = stop_active;
	end

	// Pad drivers
	gpz_pin_cell #(
		.W(P0_W)
	) u_first_port (
		.latch(first_port_latch),
		.dir(first_port_direction),
		.open_drain(first_port_drive_type),
		.force_off(p0_off),
		.pad_o(p0_out),
		.pad_oe(p0_oe)
	);

	gpz_pin_cell #(
		.W(P1_W)
	) u_second_port (
		.latch(second_port_latch),
		.dir(second_port_direction),
		.open_drain({P1_W{1'b0}}),
		.force_off(p1_off),
		.pad_o(p1_out),
		.pad_oe(p1_oe)
	);

	// No direction register: latch 1 releases the pin for input use
	gpz_pin_cell #(
		.W(P2_W)
	) u_third_port (
		.latch(third_port_latch),
		.dir({P2_W{1'b1}}),
		.open_drain({P2_W{1'b1}}),
		.force_off(p2_off),
		.pad_o(p2_out),
		.pad_oe(p2_oe)
	);

endmodule

`default_nettype wire

// *** sim/gpz_ports_asserts.sv ***
// Concurrent checks on the GPIO port block, bound to its top module.
// Assumes the register offsets of gpz_regs.svh and one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "gpz_regs.svh"

module gpz_ports_asserts
	import gpz_pkg::*;
#(
	parameter int P0_W = 4,
	parameter int P1_W = 8,
	parameter int P2_W = 3
) (
	// Clock, reset, bus
	input wire logic clk,
	input wire logic rst,
	input wire gpz_bus_req_t bus,
	input wire gpz_byte_t rdata,
	input wire logic stop_active,
	// Pins and interrupt
	input wire logic [P0_W-1:0] p0_in,
	input wire logic [P0_W-1:0] p0_out,
	input wire logic [P0_W-1:0] p0_oe,
	input wire logic [P1_W-1:0] p1_in,
	input wire logic [P1_W-1:0] p1_oe,
	input wire logic [P2_W-1:0] p2_in,
	input wire logic [P2_W-1:0] p2_oe,
	input wire logic irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_p0_reset: assert property (
		$fell(rst) |-> p0_oe == '0 && p0_out == '0)
		else $error("first port not idle after reset");
	a_p1_reset: assert property (
		$fell(rst) |-> p1_oe == '0)
		else $error("second port driving after reset");
	a_p2_reset: assert property (
		$fell(rst) |-> p2_oe == '0)
		else $error("third port driving after reset");
	a_p2_stop: assert property (
		stop_active |-> !p2_oe[0])
		else $error("pin zero driven in stop");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(bus.wr) ||
		($past(p2_in, 2) & ~$past(p2_in)) != '0)
		else $error("irq rose without cause");
	a_irq_clear: assert property (
		bus.rd && bus.addr == `GPZ_IRQ_STAT_OFS && !$past(rst) &&
		($past(p2_in) & ~p2_in) == '0 |=> !irq)
		else $error("status read left irq high");
	a_p0_read: assert property (
		$past(!rst && bus.rd && !bus.rmw && bus.addr == `GPZ_P0_LATCH_OFS)
		|-> rdata == 8'($past(p0_in)))
		else $error("first port read not pin level");
	a_p1_read: assert property (
		$past(!rst && bus.rd && bus.addr == `GPZ_P1_LATCH_OFS)
		|-> rdata == 8'($past(p1_in)))
		else $error("second port read not pin level");
	a_p2_read: assert property (
		$past(!rst && bus.rd && !bus.rmw && bus.addr == `GPZ_P2_LATCH_OFS)
		|-> rdata == 8'($past(p2_in)))
		else $error("third port read not pin level");
endmodule

bind gpz_ports gpz_ports_asserts #(.P0_W(P0_W), .P1_W(P1_W), .P2_W(P2_W))
	i_gpz_ports_asserts (.clk, .rst, .bus, .rdata, .stop_active, .p0_in,
	.p0_out, .p0_oe, .p1_in, .p1_oe, .p2_in, .p2_oe, .irq);
`default_nettype wire

// *** sim/gpz_board.sv ***
// Board side of one port: pull-ups and an optional external driver.
// Assumes pad enables are high while the port drives a pin.
`timescale 1ns/10ps
`default_nettype none

module gpz_board #(
	parameter int W = 8
) (
	// Pad drive from the port
	input wire logic [W-1:0] pad_o,
	input wire logic [W-1:0] pad_oe,
	// External driver
	input wire logic [W-1:0] ext_v,
	input wire logic [W-1:0] ext_en,
	// Resolved level
	output logic [W-1:0] pin
);
	// Released pins read high unless the external driver is enabled; contention is not modelled
	assign pin = (pad_oe & pad_o) | (~pad_oe & (~ext_en | ext_v));
endmodule
`default_nettype wire

// *** sim/gpz_ports_tb_top.sv ***
// Self-checking bench for the GPIO port block.
// Assumes the board model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none

module gpz_ports_tb_top
	import gpz_pkg::*;
();
	logic clk;
	logic rst;
	logic stop_active;
	logic irq;
	gpz_bus_req_t bus;
	gpz_byte_t rdata;
	logic [3:0] p0_in, p0_out, p0_oe, x0_v, x0_en;
	logic [7:0] p1_in, p1_out, p1_oe, x1_v, x1_en;
	logic [2:0] p2_in, p2_out, p2_oe, x2_v, x2_en;
	int bad_count;
	int total_checks;

	gpz_ports i_gpz_ports (.clk, .rst, .bus, .rdata, .stop_active, .p0_in,
		.p0_out, .p0_oe, .p1_in, .p1_out, .p1_oe, .p2_in, .p2_out, .p2_oe,
		.irq);
	gpz_board #(.W(4)) i_gpz_board_p0 (.pad_o(p0_out), .pad_oe(p0_oe),
		.ext_v(x0_v), .ext_en(x0_en), .pin(p0_in));
	gpz_board #(.W(8)) i_gpz_board_p1 (.pad_o(p1_out), .pad_oe(p1_oe),
		.ext_v(x1_v), .ext_en(x1_en), .pin(p1_in));
	gpz_board #(.W(3)) i_gpz_board_p2 (.pad_o(p2_out), .pad_oe(p2_oe),
		.ext_v(x2_v), .ext_en(x2_en), .pin(p2_in));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string n, input gpz_byte_t s, input gpz_byte_t e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask

	task automatic wr(input gpz_addr_t a, input gpz_byte_t d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, 1'b0, a, d};
		@(posedge clk);
		bus <= '0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input gpz_addr_t a, input logic m, input gpz_byte_t e,
		input string n);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, m, a, 8'h00};
		@(posedge clk);
		bus <= '0;
		#1;
		check(n, rdata, e);
	endtask

	task automatic wait_irq();
		#1;
		for (int i = 0; i < 4 && irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (irq !== 1'b1) begin
			bad_count++;
			print_verdict();
		end
	endtask

	task automatic t_reset();
		rd(16'h000A, 1'b0, 8'h00, "p0 dir");
		rd(16'h000B, 1'b0, 8'h00, "p1 dir");
		rd(16'h1F80, 1'b0, 8'h00, "p0 drive");
		rd(16'h0002, 1'b1, 8'h07, "p2 latch");
	endtask

	task automatic t_p0();
		wr(16'h1F80, 8'h0F);
		rd(16'h0000, 1'b1, 8'h00, "p0 rmw");
		wr(16'h000A, 8'hFF);
		wr(16'h0000, 8'hF5);
		check("p0 oe", 8'(p0_oe), 8'h0A);
		check("p0 out", 8'(p0_out), 8'h00);
		@(posedge clk);
		x0_en <= 4'h1;
		rd(16'h0000, 1'b0, 8'h04, "p0 pins");
		rd(16'h0000, 1'b1, 8'h05, "p0 rmw");
		wr(16'h1F80, 8'h00);
		check("p0 oe", 8'(p0_oe), 8'h0F);
		check("p0 out", 8'(p0_out), 8'h05);
		rd(16'h0100, 1'b0, 8'h00, "unmapped");
	endtask

	task automatic t_p1();
		wr(16'h000B, 8'hFF);
		rd(16'h0001, 1'b0, 8'h00, "p1 pins");
		wr(16'h0001, 8'hA5);
		check("p1 out", p1_out, 8'hA5);
		check("p1 oe", p1_oe, 8'hFF);
		wr(16'h000B, 8'h00);
		check("p1 oe", p1_oe, 8'h00);
		@(posedge clk);
		x1_en <= 8'hFF;
		x1_v <= 8'h3C;
		rd(16'h0001, 1'b1, 8'h3C, "p1 pins");
	endtask

	task automatic t_p2();
		wr(16'h0002, 8'h07);
		wr(16'h1F91, 8'h01);
		@(posedge clk);
		x2_en <= 3'h1;
		wait_irq();
		rd(16'h1F90, 1'b0, 8'h01, "status");
		check("irq", 8'(irq), 8'h00);
		@(posedge clk);
		x2_en <= 3'h0;
		// Own output pulls pin zero low, so its edge must count too
		wr(16'h0002, 8'h06);
		check("p2 oe", 8'(p2_oe), 8'h01);
		check("p2 out", 8'(p2_out), 8'h00);
		wait_irq();
		rd(16'h1F90, 1'b0, 8'h01, "status");
		wr(16'h1F92, 8'h01);
		@(posedge clk);
		stop_active <= 1'b1;
		@(posedge clk);
		#1;
		check("p2 oe", 8'(p2_oe), 8'h00);
		check("p0 oe", 8'(p0_oe), 8'h0F);
		rd(16'h0002, 1'b0, 8'h07, "p2 pins");
		rd(16'h0002, 1'b1, 8'h06, "p2 latch");
		wr(16'h1F92, 8'h00);
		check("p0 oe", 8'(p0_oe), 8'h00);
		wr(16'h0002, 8'h07);
	endtask

	task automatic print_verdict();
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		stop_active = 1'b0;
		bus = '0;
		x0_v = '0;
		x0_en = '0;
		x1_v = '0;
		x1_en = '0;
		x2_v = '0;
		x2_en = '0;
		bad_count = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_p0();
		t_p1();
		t_p2();
		print_verdict();
	end
endmodule
`default_nettype wire
